// [dami_decode.sv]
`timescale 1ns/10ps
module dami_decode
    import dami_pkg::*;
(
    input  wire logic [7:0] opcode,
    output dami_mode_t      mode,
    output dami_op_t        op,
    output logic            space,
    output logic [1:0]      len,
    output logic            valid
);
    wire logic       is_arith = (opcode <= DAMI_OPC_ARITH_LAST) && opcode[2];
    wire logic       is_cmp   = (opcode == DAMI_OPC_CMP_DIR) || (opcode == DAMI_OPC_CMP_IDX);
    wire logic       is_rlog  = (opcode >= DAMI_OPC_REG_LOGIC0) && (opcode <= DAMI_OPC_REG_LOGIC5);
    wire logic       is_rmov  = (opcode >= DAMI_OPC_MOV_REG0) && (opcode <= DAMI_OPC_MOV_REG3);
    wire logic [7:0] rlog_idx = opcode - DAMI_OPC_REG_LOGIC0;

    always_comb begin
        mode  = DAMI_M_DIR_A;
        op    = DAMI_MOV;
        space = DAMI_SPACE_RAM;
        len   = DAMI_LEN_TWO;
        valid = 1'b1;
        if (is_arith || is_cmp || is_rmov) begin
            // Compare exists only with an immediate source, direct or indexed
            mode  = is_cmp ? (opcode[0] ? DAMI_M_IDX_IMM : DAMI_M_DIR_IMM) : dami_mode_t'({1'b0, opcode[1:0]});
            op    = is_rmov ? DAMI_MOV : dami_op_t'({1'b0, opcode[5:3]});
            space = is_rmov ? DAMI_SPACE_REG : DAMI_SPACE_RAM;
            len   = (opcode[1] || is_cmp) ? DAMI_LEN_THREE : DAMI_LEN_TWO;
        end else if (is_rlog) begin
            mode  = opcode[0] ? DAMI_M_DIR_IMM : DAMI_M_IDX_IMM;
            op    = dami_op_t'(4'(DAMI_AND) + {2'h0, rlog_idx[2:1]});
            space = DAMI_SPACE_REG;
            len   = DAMI_LEN_THREE;
        end else if (opcode == DAMI_OPC_MOV_MM) begin
            mode  = DAMI_M_MOV_MM;
            len   = DAMI_LEN_THREE;
        end else if (opcode == DAMI_OPC_MVI_SRC) begin
            mode  = DAMI_M_MVI_SRC;
        end else if (opcode == DAMI_OPC_MVI_DST) begin
            mode  = DAMI_M_MVI_DST;
        end else begin
            valid = 1'b0;
        end
    end

endmodule : dami_decode

// [dami_exec.sv]
`timescale 1ns/10ps
module dami_exec
    import dami_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       start,
    input  wire logic [7:0] opcode,
    input  wire logic [7:0] operand1,
    input  wire logic [7:0] operand2,
    input  wire logic [7:0] index_x,
    input  wire logic [7:0] accum,
    input  wire logic       carry_in,
    input  wire logic [7:0] mem_rdata,
    output logic            mem_rd,
    output logic            mem_wr,
    output logic            mem_space,
    output logic [7:0]      mem_addr,
    output logic [7:0]      mem_wdata,
    output logic            acc_we,
    output logic [7:0]      acc_wdata,
    output logic            flag_we,
    output logic            flag_c_upd,
    output logic            flag_c,
    output logic            flag_z,
    output logic [1:0]      inst_len,
    output logic            illegal,
    output logic            busy,
    output logic            done
);
    // Wraps inside the 256-byte space instead of carrying out
    function automatic logic [7:0] dami_ea(input logic [7:0] base, input logic [7:0] idx, input logic use_idx);
        dami_ea = use_idx ? 8'(base + idx) : base;
    endfunction : dami_ea

    // Returns {carry, result}; subtraction carry is the borrow
    function automatic logic [8:0] dami_alu(input dami_op_t op, input logic [7:0] dst, input logic [7:0] src,
                                            input logic c);
        logic [8:0] r;
        r = {1'b0, src};
        case (op)
            DAMI_ADD: r = {1'b0, dst} + {1'b0, src};
            DAMI_ADC: r = {1'b0, dst} + {1'b0, src} + {8'h00, c};
            DAMI_SUB: r = {1'b0, dst} - {1'b0, src};
            DAMI_SBB: r = {1'b0, dst} - {1'b0, src} - {8'h00, c};
            DAMI_AND: r = {1'b0, dst & src};
            DAMI_OR:  r = {1'b0, dst | src};
            DAMI_XOR: r = {1'b0, dst ^ src};
            DAMI_CMP: r = {1'b0, dst} - {1'b0, src};
            default:  r = {1'b0, src};
        endcase
        dami_alu = r;
    endfunction : dami_alu

    dami_mode_t  dec_mode;
    dami_op_t    dec_op;
    logic        dec_space;
    logic [1:0]  dec_len;
    logic        dec_valid;

    dami_decode u_decode (
        .opcode (opcode),
        .mode   (dec_mode),
        .op     (dec_op),
        .space  (dec_space),
        .len    (dec_len),
        .valid  (dec_valid)
    );

    dami_state_t state, next_state;
    dami_mode_t  mode, next_mode;
    dami_op_t    op, next_op;
    logic [7:0]  dst_addr, next_dst_addr;
    logic [7:0]  src_val, next_src_val;
    logic [7:0]  ptr, next_ptr;
    logic        carry_lat, next_carry_lat;
    logic        next_mem_rd, next_mem_wr, next_mem_space;
    logic [7:0]  next_mem_addr, next_mem_wdata, next_acc_wdata;
    logic        next_acc_we, next_flag_we, next_flag_c_upd, next_flag_c, next_flag_z;
    logic [1:0]  next_inst_len;
    logic        next_illegal, next_done;

    // Indexed modes add the index register, direct ones use operand one as is
    wire logic       dec_indexed = (dec_mode == DAMI_M_IDX_A) || (dec_mode == DAMI_M_IDX_IMM);
    wire logic [7:0] dec_ea      = dami_ea(operand1, index_x, dec_indexed);
    wire logic       dec_imm     = (dec_mode == DAMI_M_DIR_IMM) || (dec_mode == DAMI_M_IDX_IMM);
    wire logic [7:0] dec_src     = dec_imm ? operand2 : accum;
    wire logic [8:0] alu_out     = dami_alu(op, mem_rdata, src_val, carry_lat);
    wire logic [7:0] ptr_inc     = dami_ea(ptr, DAMI_PTR_STEP, 1'b1);
    wire logic       op_arith    = (op == DAMI_ADD) || (op == DAMI_ADC) || (op == DAMI_SUB) ||
                                   (op == DAMI_SBB) || (op == DAMI_CMP);

    always_comb begin
        next_state      = state;
        next_mode       = mode;
        next_op         = op;
        next_dst_addr   = dst_addr;
        next_src_val    = src_val;
        next_ptr        = ptr;
        next_carry_lat  = carry_lat;
        next_mem_rd     = 1'b0;
        next_mem_wr     = 1'b0;
        next_mem_space  = mem_space;
        next_mem_addr   = mem_addr;
        next_mem_wdata  = mem_wdata;
        next_acc_we     = 1'b0;
        next_acc_wdata  = acc_wdata;
        next_flag_we    = 1'b0;
        next_flag_c_upd = flag_c_upd;
        next_flag_c     = flag_c;
        next_flag_z     = flag_z;
        next_inst_len   = inst_len;
        next_illegal    = 1'b0;
        next_done       = 1'b0;
        case (state)
            DAMI_S_IDLE: begin
                if (start && !dec_valid) begin
                    next_illegal = 1'b1;
                end else if (start) begin
                    next_inst_len  = dec_len;
                    next_mode      = dec_mode;
                    next_op        = dec_op;
                    next_src_val   = dec_src;
                    next_carry_lat = carry_in;
                    next_dst_addr  = (dec_mode == DAMI_M_MVI_SRC || dec_mode == DAMI_M_MVI_DST ||
                                      dec_mode == DAMI_M_MOV_MM) ? operand1 : dec_ea;
                    next_mem_space = dec_space;
                    if (dec_mode == DAMI_M_MVI_SRC || dec_mode == DAMI_M_MVI_DST) begin
                        next_mem_addr  = operand1;
                        next_mem_space = DAMI_SPACE_RAM;
                        next_mem_rd    = 1'b1;
                        next_state     = DAMI_S_RD1;
                    end else if (dec_mode == DAMI_M_MOV_MM) begin
                        next_mem_addr  = operand2;
                        next_mem_space = DAMI_SPACE_RAM;
                        next_mem_rd    = 1'b1;
                        next_state     = DAMI_S_RD1;
                    end else if (dec_op == DAMI_MOV) begin
                        // A plain move needs no read of the old destination
                        next_mem_addr  = dec_ea;
                        next_mem_wdata = dec_src;
                        next_mem_wr    = 1'b1;
                        next_state     = DAMI_S_WR;
                    end else begin
                        next_mem_addr  = dec_ea;
                        next_mem_rd    = 1'b1;
                        next_state     = DAMI_S_RD1;
                    end
                end
            end
            DAMI_S_RD1: begin
                next_state = DAMI_S_GET1;
            end
            DAMI_S_GET1: begin
                case (mode)
                    DAMI_M_MVI_SRC: begin
                        next_ptr      = mem_rdata;
                        next_mem_addr = mem_rdata;
                        next_mem_rd   = 1'b1;
                        next_state    = DAMI_S_RD2;
                    end
                    DAMI_M_MVI_DST: begin
                        next_ptr       = mem_rdata;
                        next_mem_addr  = mem_rdata;
                        next_mem_wdata = src_val;
                        next_mem_wr    = 1'b1;
                        next_state     = DAMI_S_WR;
                    end
                    DAMI_M_MOV_MM: begin
                        next_mem_addr  = dst_addr;
                        next_mem_wdata = mem_rdata;
                        next_mem_wr    = 1'b1;
                        next_state     = DAMI_S_WR;
                    end
                    default: begin
                        next_flag_we    = 1'b1;
                        next_flag_c_upd = op_arith;
                        next_flag_c     = op_arith ? alu_out[8] : flag_c;
                        next_flag_z     = (alu_out[7:0] == 8'h00);
                        if (op == DAMI_CMP) begin
                            // Compare only sets flags; the location is not rewritten
                            next_done  = 1'b1;
                            next_state = DAMI_S_IDLE;
                        end else begin
                            next_mem_addr  = dst_addr;
                            next_mem_wdata = alu_out[7:0];
                            next_mem_wr    = 1'b1;
                            next_state     = DAMI_S_WR;
                        end
                    end
                endcase
            end
            DAMI_S_RD2: begin
                next_state = DAMI_S_GET2;
            end
            DAMI_S_GET2: begin
                next_acc_we     = 1'b1;
                next_acc_wdata  = mem_rdata;
                next_flag_we    = 1'b1;
                next_flag_c_upd = 1'b0;
                next_flag_z     = (mem_rdata == 8'h00);
                next_mem_addr   = dst_addr;
                next_mem_wdata  = ptr_inc;
                next_mem_wr     = 1'b1;
                next_state      = DAMI_S_WRP;
            end
            DAMI_S_WR: begin
                if (mode == DAMI_M_MVI_DST) begin
                    // Pointer goes back only after the data store
                    next_mem_addr  = dst_addr;
                    next_mem_wdata = ptr_inc;
                    next_mem_wr    = 1'b1;
                    next_state     = DAMI_S_WRP;
                end else begin
                    next_done  = 1'b1;
                    next_state = DAMI_S_IDLE;
                end
            end
            DAMI_S_WRP: begin
                next_done  = 1'b1;
                next_state = DAMI_S_IDLE;
            end
            default: begin
                next_state = DAMI_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state      <= DAMI_S_IDLE;
            mode       <= DAMI_M_DIR_A;
            op         <= DAMI_MOV;
            dst_addr   <= DAMI_BYTE_RESET;
            src_val    <= DAMI_BYTE_RESET;
            ptr        <= DAMI_BYTE_RESET;
            carry_lat  <= 1'b0;
            mem_rd     <= 1'b0;
            mem_wr     <= 1'b0;
            mem_space  <= DAMI_SPACE_RAM;
            mem_addr   <= DAMI_BYTE_RESET;
            mem_wdata  <= DAMI_BYTE_RESET;
            acc_we     <= 1'b0;
            acc_wdata  <= DAMI_BYTE_RESET;
            flag_we    <= 1'b0;
            flag_c_upd <= 1'b0;
            flag_c     <= 1'b0;
            flag_z     <= 1'b0;
            inst_len   <= DAMI_LEN_RESET;
            illegal    <= 1'b0;
            busy       <= 1'b0;
            done       <= 1'b0;
        end else begin
            state      <= next_state;
            mode       <= next_mode;
            op         <= next_op;
            dst_addr   <= next_dst_addr;
            src_val    <= next_src_val;
            ptr        <= next_ptr;
            carry_lat  <= next_carry_lat;
            mem_rd     <= next_mem_rd;
            mem_wr     <= next_mem_wr;
            mem_space  <= next_mem_space;
            mem_addr   <= next_mem_addr;
            mem_wdata  <= next_mem_wdata;
            acc_we     <= next_acc_we;
            acc_wdata  <= next_acc_wdata;
            flag_we    <= next_flag_we;
            flag_c_upd <= next_flag_c_upd;
            flag_c     <= next_flag_c;
            flag_z     <= next_flag_z;
            inst_len   <= next_inst_len;
            illegal    <= next_illegal;
            busy       <= (next_state != DAMI_S_IDLE);
            done       <= next_done;
        end
    end

endmodule : dami_exec

// [dami_exec_assertions.sv]
`timescale 1ns/10ps
module dami_exec_assertions
    import dami_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       start,
    input wire logic       busy,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [7:0] operand2,
    input wire logic [7:0] index_x,
    input wire logic [7:0] accum,
    input wire logic [7:0] mem_rdata,
    input wire logic       mem_rd,
    input wire logic       mem_wr,
    input wire logic       mem_space,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic       acc_we,
    input wire logic [7:0] acc_wdata,
    input wire logic [1:0] inst_len
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    wire logic take    = start && !busy;
    wire logic idx_alu = take && opcode[2:0] == 3'h5 && opcode <= DAMI_OPC_ARITH_LAST;
    wire logic imm_alu = take && opcode[2:1] == 2'h3 && opcode <= DAMI_OPC_ARITH_LAST;

    property p_idx_addr;
        idx_alu |=> mem_rd && !mem_space && mem_addr == 8'($past(operand1) + $past(index_x));
    endproperty
    a_idx_addr: assert property (p_idx_addr)
        else $error("indexed destination address wrong");
    property p_idx_acc;
        idx_alu |=> !acc_we [*4];
    endproperty
    a_idx_acc: assert property (p_idx_acc)
        else $error("accumulator written by destination mode");
    property p_idx_len;
        idx_alu |=> ##1 inst_len == DAMI_LEN_TWO;
    endproperty
    a_idx_len: assert property (p_idx_len)
        else $error("indexed destination length wrong");
    property p_imm_len;
        imm_alu |=> ##1 inst_len == DAMI_LEN_THREE;
    endproperty
    a_imm_len: assert property (p_imm_len)
        else $error("immediate source length wrong");
    property p_mov_reg;
        take && opcode >= DAMI_OPC_MOV_REG0 && opcode <= DAMI_OPC_MOV_REG3 |=> mem_wr && mem_space == DAMI_SPACE_REG
            && mem_addr == ($past(opcode[0]) ? 8'($past(operand1) + $past(index_x)) : $past(operand1))
            && mem_wdata == ($past(opcode[1]) ? $past(operand2) : $past(accum));
    endproperty
    a_mov_reg: assert property (p_mov_reg)
        else $error("register space move wrong");
    property p_mov_mm;
        take && opcode == DAMI_OPC_MOV_MM |=> mem_rd && !mem_space && mem_addr == $past(operand2)
            ##2 mem_wr && !mem_space && mem_addr == $past(operand1, 3) && mem_wdata == $past(mem_rdata);
    endproperty
    a_mov_mm: assert property (p_mov_mm)
        else $error("memory to memory move wrong");
    property p_mvi_src;
        take && opcode == DAMI_OPC_MVI_SRC |=> mem_rd && mem_addr == $past(operand1)
            ##2 mem_rd && mem_addr == $past(mem_rdata)
            ##2 acc_we && acc_wdata == $past(mem_rdata) && mem_wr && mem_addr == $past(operand1, 5)
            && mem_wdata == 8'($past(mem_addr, 2) + DAMI_PTR_STEP);
    endproperty
    a_mvi_src: assert property (p_mvi_src)
        else $error("indirect load sequence wrong");
    property p_mvi_dst;
        take && opcode == DAMI_OPC_MVI_DST |=> mem_rd && mem_addr == $past(operand1)
            ##2 mem_wr && mem_addr == $past(mem_rdata) && mem_wdata == $past(accum, 3)
            ##1 mem_wr && mem_addr == $past(operand1, 4) && mem_wdata == 8'($past(mem_addr) + DAMI_PTR_STEP);
    endproperty
    a_mvi_dst: assert property (p_mvi_dst)
        else $error("indirect store sequence wrong");
    property p_mvi_len;
        take && (opcode == DAMI_OPC_MVI_SRC || opcode == DAMI_OPC_MVI_DST) |=> ##1 inst_len == DAMI_LEN_TWO;
    endproperty
    a_mvi_len: assert property (p_mvi_len)
        else $error("indirect move length wrong");
endmodule : dami_exec_assertions

bind dami_exec dami_exec_assertions i_dami_exec_assertions (.clk_sys, .reset, .start, .busy, .opcode, .operand1,
    .operand2, .index_x, .accum, .mem_rdata, .mem_rd, .mem_wr, .mem_space, .mem_addr, .mem_wdata, .acc_we,
    .acc_wdata, .inst_len);

// [dami_mem_model.sv]
`timescale 1ns/10ps
module dami_mem_model (
    input  wire logic       clk_sys,
    input  wire logic       mem_rd,
    input  wire logic       mem_wr,
    input  wire logic       mem_space,
    input  wire logic [7:0] mem_addr,
    input  wire logic [7:0] mem_wdata,
    output logic [7:0]      mem_rdata
);
    logic [7:0] ram  [256];
    logic [7:0] regs [256];

    initial mem_rdata = 8'h00;

    // Data is valid one cycle only; it toggles afterwards so a late sample cannot pass
    always @(posedge clk_sys) begin
        if (mem_rd) begin
            mem_rdata <= mem_space ? regs[mem_addr] : ram[mem_addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem_wr && mem_space) begin
            regs[mem_addr] <= mem_wdata;
        end else if (mem_wr) begin
            ram[mem_addr] <= mem_wdata;
        end
    end
endmodule : dami_mem_model

// [dami_pkg.sv]
package dami_pkg;

    localparam logic [7:0] DAMI_BYTE_RESET = 8'h00;
    localparam logic [1:0] DAMI_LEN_TWO    = 2'h2;
    localparam logic [1:0] DAMI_LEN_THREE  = 2'h3;
    localparam logic [1:0] DAMI_LEN_RESET  = 2'h0;
    localparam logic       DAMI_SPACE_RAM  = 1'b0;
    localparam logic       DAMI_SPACE_REG  = 1'b1;
    localparam logic [7:0] DAMI_PTR_STEP   = 8'h01;

    localparam logic [7:0] DAMI_OPC_ARITH_LAST = 8'h37;
    localparam logic [7:0] DAMI_OPC_CMP_DIR    = 8'h3c;
    localparam logic [7:0] DAMI_OPC_CMP_IDX    = 8'h3d;
    localparam logic [7:0] DAMI_OPC_MVI_SRC    = 8'h3e;
    localparam logic [7:0] DAMI_OPC_MVI_DST    = 8'h3f;
    localparam logic [7:0] DAMI_OPC_REG_LOGIC0 = 8'h41;
    localparam logic [7:0] DAMI_OPC_REG_LOGIC5 = 8'h46;
    localparam logic [7:0] DAMI_OPC_MOV_MM     = 8'h5f;
    localparam logic [7:0] DAMI_OPC_MOV_REG0   = 8'h60;
    localparam logic [7:0] DAMI_OPC_MOV_REG3   = 8'h63;

    typedef enum logic [3:0] {
        DAMI_ADD = 4'h0,
        DAMI_ADC = 4'h1,
        DAMI_SUB = 4'h2,
        DAMI_SBB = 4'h3,
        DAMI_AND = 4'h4,
        DAMI_OR  = 4'h5,
        DAMI_XOR = 4'h6,
        DAMI_CMP = 4'h7,
        DAMI_MOV = 4'h8
    } dami_op_t;

    typedef enum logic [2:0] {
        DAMI_M_DIR_A   = 3'h0,
        DAMI_M_IDX_A   = 3'h1,
        DAMI_M_DIR_IMM = 3'h2,
        DAMI_M_IDX_IMM = 3'h3,
        DAMI_M_MOV_MM  = 3'h4,
        DAMI_M_MVI_SRC = 3'h5,
        DAMI_M_MVI_DST = 3'h6
    } dami_mode_t;

    typedef enum logic [6:0] {
        DAMI_S_IDLE = 7'h01,
        DAMI_S_RD1  = 7'h02,
        DAMI_S_GET1 = 7'h04,
        DAMI_S_RD2  = 7'h08,
        DAMI_S_GET2 = 7'h10,
        DAMI_S_WR   = 7'h20,
        DAMI_S_WRP  = 7'h40
    } dami_state_t;

endpackage : dami_pkg

// [test_dest_and_indirect_addr_modes.sv]
`timescale 1ns/10ps
module test_dest_and_indirect_addr_modes;
    import dami_pkg::*;
    logic       clk_sys  = 1'b0;
    logic       reset    = 1'b1;
    logic       start    = 1'b0;
    logic [7:0] opcode   = 8'h00;
    logic [7:0] operand1 = 8'h00;
    logic [7:0] operand2 = 8'h00;
    logic [7:0] index_x  = 8'h00;
    logic [7:0] accum    = 8'h00;
    logic       carry_in = 1'b0;
    wire  [7:0] mem_rdata;
    wire        mem_rd, mem_wr, mem_space, acc_we, busy, done;
    wire        illegal, flag_we, flag_c_upd, flag_c, flag_z;
    wire  [7:0] mem_addr, mem_wdata, acc_wdata;
    wire  [1:0] inst_len;
    logic       saw_acc, saw_flag;
    int         num_errors = 0;
    int         checks     = 0;

    dami_exec i_dami_exec (.clk_sys, .reset, .start, .opcode, .operand1, .operand2, .index_x, .accum, .carry_in,
        .mem_rdata, .mem_rd, .mem_wr, .mem_space, .mem_addr, .mem_wdata, .acc_we, .acc_wdata, .flag_we,
        .flag_c_upd, .flag_c, .flag_z, .inst_len, .illegal, .busy, .done);
    dami_mem_model i_dami_mem_model (.clk_sys, .mem_rd, .mem_wr, .mem_space, .mem_addr, .mem_wdata, .mem_rdata);

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] alu(input logic [2:0] k, input logic [7:0] d, input logic [7:0] s, input logic c);
        case (k)
            3'h0: return d + s;
            3'h1: return d + s + {7'h00, c};
            3'h2: return d - s;
            3'h3: return d - s - {7'h00, c};
            3'h4: return d & s;
            3'h5: return d | s;
            default: return d ^ s;
        endcase
    endfunction : alu

    task automatic issue(input logic [7:0] op, o1, o2, x, a);
        int n;
        @(posedge clk_sys);
        #1;
        start = 1'b1;
        opcode = op;
        operand1 = o1;
        operand2 = o2;
        index_x = x;
        accum = a;
        @(posedge clk_sys);
        #1;
        start = 1'b0;
        saw_acc = acc_we;
        saw_flag = flag_we;
        for (n = 0; n < 20 && done !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
            saw_acc = saw_acc | acc_we;
            saw_flag = saw_flag | flag_we;
        end
        chk({7'h00, done}, 8'h01);
    endtask : issue

    // Sum wraps past 0xff so the modulo behaviour is exercised on every operation
    task automatic t_dst_idx();
        for (int k = 0; k < 7; k++) begin
            i_dami_mem_model.ram[8'h10] = 8'h35 + 8'(k);
            carry_in = k[0];
            issue(8'h05 + 8'(k * 8), 8'hf0, 8'h00, 8'h20, 8'h17);
            chk(i_dami_mem_model.ram[8'h10], alu(3'(k), 8'h35 + 8'(k), 8'h17, k[0]));
            chk({7'h00, saw_acc}, 8'h00);
            chk({6'h00, inst_len}, {6'h00, DAMI_LEN_TWO});
        end
    endtask : t_dst_idx

    task automatic t_dst_imm();
        i_dami_mem_model.ram[8'h07] = 8'h0a;
        issue(8'h06, 8'h07, 8'h05, 8'h33, 8'h00);
        chk(i_dami_mem_model.ram[8'h07], 8'h0f);
        chk({6'h00, inst_len}, {6'h00, DAMI_LEN_THREE});
        i_dami_mem_model.ram[8'h00] = 8'h20;
        issue(8'h07, 8'hf8, 8'h03, 8'h08, 8'h00);
        chk(i_dami_mem_model.ram[8'h00], 8'h23);
        chk({6'h00, inst_len}, {6'h00, DAMI_LEN_THREE});
        i_dami_mem_model.ram[8'h0c] = 8'h77;
        for (int k = 0; k < 4; k++) begin
            issue(DAMI_OPC_MOV_REG0 + 8'(k), 8'h08, 8'h06, 8'h04, 8'hc3 + 8'(k));
            chk(i_dami_mem_model.regs[k[0] ? 8'h0c : 8'h08], k[1] ? 8'h06 : 8'hc3 + 8'(k));
        end
        chk(i_dami_mem_model.ram[8'h0c], 8'h77);
    endtask : t_dst_imm

    task automatic t_mov_mm();
        i_dami_mem_model.ram[8'h08] = 8'h5a;
        i_dami_mem_model.ram[8'h07] = 8'h00;
        issue(DAMI_OPC_MOV_MM, 8'h07, 8'h08, 8'h00, 8'h00);
        chk(i_dami_mem_model.ram[8'h07], 8'h5a);
        chk({6'h00, inst_len}, {6'h00, DAMI_LEN_THREE});
    endtask : t_mov_mm

    task automatic t_mvi();
        i_dami_mem_model.ram[8'h08] = 8'hff;
        i_dami_mem_model.ram[8'hff] = 8'h3c;
        issue(DAMI_OPC_MVI_SRC, 8'h08, 8'h00, 8'h00, 8'h00);
        chk(acc_wdata, 8'h3c);
        chk({7'h00, saw_acc}, 8'h01);
        chk({6'h00, saw_flag, flag_z}, 8'h02);
        chk(i_dami_mem_model.ram[8'h08], 8'h00);
        chk({6'h00, inst_len}, {6'h00, DAMI_LEN_TWO});
        i_dami_mem_model.ram[8'h09] = 8'h40;
        issue(DAMI_OPC_MVI_DST, 8'h09, 8'h00, 8'h00, 8'ha5);
        chk(i_dami_mem_model.ram[8'h40], 8'ha5);
        chk(i_dami_mem_model.ram[8'h09], 8'h41);
        chk({6'h00, inst_len}, {6'h00, DAMI_LEN_TWO});
    endtask : t_mvi

    // An opcode outside this block gets one illegal pulse and no memory traffic
    task automatic t_illegal();
        @(posedge clk_sys);
        #1;
        start = 1'b1;
        opcode = 8'h30;
        @(posedge clk_sys);
        #1;
        start = 1'b0;
        chk({4'h0, illegal, busy, mem_rd, mem_wr}, 8'h08);
        @(posedge clk_sys);
        #1;
        chk({6'h00, illegal, busy}, 8'h00);
        chk({6'h00, inst_len}, {6'h00, DAMI_LEN_TWO});
    endtask : t_illegal

    // Compare reads the destination and sets flags but never rewrites it
    task automatic t_cmp();
        i_dami_mem_model.ram[8'h30] = 8'h10;
        issue(DAMI_OPC_CMP_DIR, 8'h30, 8'h20, 8'h00, 8'h00);
        chk({5'h00, saw_flag, flag_c_upd, flag_c}, 8'h07);
        chk({7'h00, flag_z}, 8'h00);
        chk({6'h00, inst_len}, {6'h00, DAMI_LEN_THREE});
        issue(DAMI_OPC_CMP_IDX, 8'h28, 8'h10, 8'h08, 8'h00);
        chk({6'h00, flag_c, flag_z}, 8'h01);
        chk(i_dami_mem_model.ram[8'h30], 8'h10);
        chk({6'h00, inst_len}, {6'h00, DAMI_LEN_THREE});
    endtask : t_cmp

    task automatic t_reg_logic();
        i_dami_mem_model.regs[8'h20] = 8'hf0;
        issue(DAMI_OPC_REG_LOGIC0, 8'h20, 8'h3c, 8'h00, 8'h00);
        chk(i_dami_mem_model.regs[8'h20], 8'h30);
        chk({6'h00, saw_flag, flag_z}, 8'h02);
        issue(DAMI_OPC_REG_LOGIC5, 8'h1c, 8'h30, 8'h04, 8'h00);
        chk(i_dami_mem_model.regs[8'h20], 8'h00);
        chk({6'h00, flag_c_upd, flag_z}, 8'h01);
        chk({6'h00, inst_len}, {6'h00, DAMI_LEN_THREE});
    endtask : t_reg_logic

    initial begin
        repeat (4) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        chk({6'h00, inst_len}, {6'h00, DAMI_LEN_RESET});
        t_dst_idx();
        t_dst_imm();
        t_mov_mm();
        t_mvi();
        t_illegal();
        t_cmp();
        t_reg_logic();
        summarize();
    end

    // About 20 instructions plus one illegal opcode, at most 10 cycles each; this leaves ample margin
    initial begin
        repeat (2000) @(posedge clk_sys);
        num_errors++;
        summarize();
    end
endmodule : test_dest_and_indirect_addr_modes
